// ---- srps_ctrl.sv ----
`timescale 1ns/1ns
`default_nettype none

// How it works
// [RULE1] one auto refresh command is issued for every refresh owed
// [RULE2] open banks are closed by precharge-all before any refresh
// [RULE3] refresh waits the precharge time after the precharge-all
// [RULE4] device takes the refresh row internally; address is driven zero
// [RULE5] only nop is driven until the refresh cycle time has passed
// [RULE6] distributed mode owes one refresh per period divided by rows
// [RULE7] burst mode owes a full row count each period, spaced minimally
// [RULE8] self refresh entry is refresh with cke low, then cke held low
// [RULE9] device refreshes itself in self refresh; no commands are sent
// [RULE10] self refresh lasts at least the row active time
// [RULE11] exit raises cke on a running clock, then nops for exit time
// [RULE12] after self refresh exit the distributed timer restarts
// [RULE13] power-down entry is cke low with nop while nothing runs
// [RULE14] device drops its buffers in power-down; only cke is driven
// [RULE15] power-down ends as soon as a refresh becomes owed
// [RULE16] power-down exit is cke high together with a nop
// [RULE17] suspend request drops cke while a burst runs
// [RULE18] no new command is offered while the clock is suspended
// [RULE19] raising cke resumes the burst on the next edge
// [RULE20] precharge with the all bit closes every bank, else one bank
// [RULE21] refresh and self refresh share one code, differ only in cke
module srps_ctrl
  import srps_pkg::*;
#(
  parameter int REF_PERIOD_CYC = srps_pkg::REFRESH_PERIOD_CYC,
  parameter int REF_INTERVAL_CYC = srps_pkg::REFRESH_INTERVAL_CYC
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // user command port
  input wire srps_pkg::srps_cmd_t usr_cmd,
  input wire logic usr_valid,
  output logic usr_ready,
  // mode requests
  input wire logic burst_mode,
  input wire logic pd_req,
  input wire logic sr_req,
  input wire logic suspend_req,
  // status
  output logic in_power_down,
  output logic in_self_refresh,
  output logic refresh_busy,
  // sdram pins
  output srps_pkg::srps_pins_t pins
);
  import srps_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  srps_state_t state;
  srps_state_t next_state;
  srps_pins_t next_pins;
  logic [WAIT_W-1:0] wait_cnt;
  logic [WAIT_W-1:0] next_wait;
  logic [TIMER_W-1:0] timer;
  logic [OWED_W-1:0] owed;
  logic [3:0] open_banks;
  logic issue_ref;
  logic issue_pre_all;
  logic timer_restart;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire logic ref_due = (owed != '0);
  wire logic any_open = (open_banks != BANKS_NONE);
  wire logic wait_done = (wait_cnt == '0);
  wire logic timer_tick = (timer == '0);
  wire logic usr_fire = usr_valid && usr_ready;
  wire logic [3:0] usr_code = {usr_cmd.cs_n, usr_cmd.ras_n, usr_cmd.cas_n, usr_cmd.we_n};
  wire logic [3:0] usr_bank_bit = 4'h1 << usr_cmd.ba;
  wire logic usr_act = usr_fire && (usr_code == CMD_ACTIVE);
  wire logic usr_pre = usr_fire && (usr_code == CMD_PRECHARGE);
  wire logic usr_pre_all = usr_cmd.addr[PRE_ALL_BIT];
  wire logic [TIMER_W-1:0] reload_period = TIMER_W'(REF_PERIOD_CYC - 1);
  wire logic [TIMER_W-1:0] reload_interval = TIMER_W'(REF_INTERVAL_CYC - 1);
  wire logic [TIMER_W-1:0] timer_reload = burst_mode ? reload_period : reload_interval;
  wire logic [OWED_W:0] owed_add = burst_mode ? (OWED_W+1)'(ROW_COUNT) : (OWED_W+1)'(1);
  wire logic [OWED_W:0] owed_sum = {1'b0, owed} + owed_add;
  wire logic [OWED_W-1:0] owed_max = '1;
  // suspended cycles take no command, so the user port is held off
  wire logic usr_open = !ref_due && !sr_req && !pd_req && !suspend_req; // see [RULE18]
  // a command on the edge that raises cke would be lost at the device
  assign usr_ready = (state == ST_IDLE) && usr_open && pins.cke; // see [RULE19]
  assign in_power_down = (state == ST_POWER_DOWN);
  assign in_self_refresh = (state == ST_SELF_REF) || (state == ST_SR_EXIT);
  assign refresh_busy = (state == ST_PRE_WAIT) || (state == ST_REF_WAIT);

  // helper: pin word from a command code
  function automatic srps_pins_t mk(input logic cke, input logic [3:0] code,
                                    input logic [ADDR_W-1:0] addr);
    srps_pins_t p;
    p.cke = cke;
    p.cmd.cs_n = code[3];
    p.cmd.ras_n = code[2];
    p.cmd.cas_n = code[1];
    p.cmd.we_n = code[0];
    p.cmd.ba = 2'h0;
    p.cmd.addr = addr;
    return p;
  endfunction

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  // one place decides both the next state and the next pin word
  always_comb begin
    next_state = state;
    next_pins = mk(1'b1, CMD_NOP, '0);
    next_wait = (wait_cnt == '0) ? wait_cnt : wait_cnt - WAIT_W'(1);
    issue_ref = 1'b0;
    issue_pre_all = 1'b0;
    timer_restart = 1'b0;
    unique case (state)
      ST_IDLE: begin
        if (!pins.cke) begin
          // the edge that raises cke is still suspended inside the device
          next_pins = mk(!suspend_req || ref_due || sr_req || pd_req, CMD_NOP, '0); // see [RULE19]
        end else if ((ref_due || sr_req) && any_open) begin
          next_pins = mk(1'b1, CMD_PRECHARGE, ADDR_W'(1) << PRE_ALL_BIT); // see [RULE2]
          issue_pre_all = 1'b1;
          next_wait = WAIT_W'(PRECHARGE_CYC - 1); // see [RULE3]
          next_state = ST_PRE_WAIT;
        end else if (sr_req) begin
          // self refresh is the refresh code with cke low
          next_pins = mk(1'b0, CMD_REFRESH, '0); // see [RULE8] [RULE21]
          next_wait = WAIT_W'(ROW_ACTIVE_CYC - 1); // see [RULE10]
          next_state = ST_SELF_REF;
        end else if (ref_due) begin
          next_pins = mk(1'b1, CMD_REFRESH, '0); // see [RULE1] [RULE4]
          issue_ref = 1'b1;
          next_wait = WAIT_W'(REFRESH_CYCLE_CYC - 1);
          next_state = ST_REF_WAIT;
        end else if (pd_req) begin
          next_pins = mk(1'b0, CMD_NOP, '0); // see [RULE13]
          next_state = ST_POWER_DOWN;
        end else if (usr_fire) begin
          next_pins.cmd = usr_cmd;
        end else begin
          // cke low mid-burst freezes the device burst counter
          next_pins = mk(!suspend_req, CMD_NOP, '0); // see [RULE17] [RULE19]
        end
      end
      ST_PRE_WAIT: begin
        if (wait_done) begin
          if (sr_req) begin
            next_pins = mk(1'b0, CMD_REFRESH, '0); // see [RULE8] [RULE21]
            next_wait = WAIT_W'(ROW_ACTIVE_CYC - 1); // see [RULE10]
            next_state = ST_SELF_REF;
          end else if (ref_due) begin
            next_pins = mk(1'b1, CMD_REFRESH, '0); // see [RULE1] [RULE3]
            issue_ref = 1'b1;
            next_wait = WAIT_W'(REFRESH_CYCLE_CYC - 1);
            next_state = ST_REF_WAIT;
          end else begin
            next_state = ST_IDLE;
          end
        end
      end
      ST_REF_WAIT: begin
        // nop on every edge until the refresh cycle has run
        if (wait_done) begin
          next_state = ST_IDLE; // see [RULE5] [RULE7]
        end
      end
      ST_POWER_DOWN: begin
        // a refresh owed cuts power-down short, data would decay
        if (!pd_req || ref_due || sr_req) begin
          next_pins = mk(1'b1, CMD_NOP, '0); // see [RULE15] [RULE16]
          next_state = ST_IDLE;
        end else begin
          next_pins = mk(1'b0, CMD_NOP, '0); // see [RULE14]
        end
      end
      ST_SELF_REF: begin
        // clock keeps running, so cke can rise on a stable clock
        if (wait_done && !sr_req) begin
          next_pins = mk(1'b1, CMD_NOP, '0); // see [RULE11]
          next_wait = WAIT_W'(SELF_REFRESH_EXIT_CYC - 1);
          next_state = ST_SR_EXIT;
        end else begin
          next_pins = mk(1'b0, CMD_NOP, '0); // see [RULE8] [RULE9]
        end
      end
      ST_SR_EXIT: begin
        if (wait_done) begin
          timer_restart = 1'b1; // see [RULE12]
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  // state, wait counter and pins
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= ST_IDLE;
      wait_cnt <= '0;
      pins <= mk(1'b0, 4'hF, '0);
    end else if (ce) begin
      state <= next_state;
      wait_cnt <= next_wait;
      pins <= next_pins;
    end
  end

  // refresh timer; restart after self refresh puts it back on rate
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      timer <= '0;
    end else if (ce) begin
      if (timer_restart || timer_tick) begin
        timer <= timer_reload; // see [RULE6] [RULE7] [RULE12]
      end else begin
        timer <= timer - TIMER_W'(1);
      end
    end
  end

  // refreshes owed; saturates rather than wrapping
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      owed <= '0;
    end else if (ce) begin
      if (in_self_refresh) begin
        owed <= '0; // see [RULE9]
      end else if (timer_tick && !timer_restart) begin
        owed <= owed_sum[OWED_W] ? owed_max : owed_sum[OWED_W-1:0] - OWED_W'(issue_ref);
      end else if (issue_ref) begin
        owed <= owed - OWED_W'(1); // see [RULE1]
      end
    end
  end

  // open bank tracking from the commands that reach the pins
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      open_banks <= BANKS_NONE;
    end else if (ce) begin
      if (issue_pre_all || (usr_pre && usr_pre_all)) begin
        open_banks <= BANKS_NONE; // see [RULE20]
      end else if (usr_pre) begin
        open_banks <= open_banks & ~usr_bank_bit; // see [RULE20]
      end else if (usr_act) begin
        open_banks <= open_banks | usr_bank_bit;
      end
    end
  end

endmodule // srps_ctrl
`default_nettype wire

// ---- srps_pkg.sv ----
`default_nettype none
package srps_pkg;

  // ---------------------------------------------------------------
  // clock and timing figures
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int PRECHARGE_TIME_NS = 20;
  localparam int REFRESH_CYCLE_TIME_NS = 70;
  localparam int ROW_ACTIVE_TIME_NS = 42;
  localparam int SELF_REFRESH_EXIT_TIME_NS = 70;
  localparam int SELF_REFRESH_EXIT_MIN_CLKS = 2;
  localparam int REFRESH_PERIOD_MS = 64;
  localparam int ROW_COUNT = 4096;
  localparam int NS_PER_MS = 1000000;

  // least times round up, never below one cycle
  function automatic int cycles_up(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int PRECHARGE_CYC = cycles_up(PRECHARGE_TIME_NS);
  localparam int REFRESH_CYCLE_CYC = cycles_up(REFRESH_CYCLE_TIME_NS);
  localparam int ROW_ACTIVE_CYC = cycles_up(ROW_ACTIVE_TIME_NS);
  localparam int XSR_RAW_CYC = cycles_up(SELF_REFRESH_EXIT_TIME_NS);
  localparam int SELF_REFRESH_EXIT_CYC =
    (XSR_RAW_CYC < SELF_REFRESH_EXIT_MIN_CLKS) ? SELF_REFRESH_EXIT_MIN_CLKS : XSR_RAW_CYC;
  // longest time: rounds down
  localparam int REFRESH_PERIOD_CYC = REFRESH_PERIOD_MS * (NS_PER_MS / CLK_PERIOD_NS);
  localparam int REFRESH_INTERVAL_CYC = REFRESH_PERIOD_CYC / ROW_COUNT;

  // ---------------------------------------------------------------
  // widths, fields and command codes {cs_n, ras_n, cas_n, we_n}
  // ---------------------------------------------------------------
  localparam int WAIT_W = 16;
  localparam int TIMER_W = 22;
  localparam int OWED_W = 13;
  localparam int ADDR_W = 12;
  localparam int PRE_ALL_BIT = 10;
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_REFRESH = 4'h1;
  localparam logic [3:0] CMD_PRECHARGE = 4'h2;
  localparam logic [3:0] CMD_ACTIVE = 4'h3;
  localparam logic [3:0] BANKS_NONE = 4'h0;

  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [1:0] ba;
    logic [ADDR_W-1:0] addr;
  } srps_cmd_t;

  typedef struct packed {
    logic cke;
    srps_cmd_t cmd;
  } srps_pins_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_PRE_WAIT = 3'h1,
    ST_REF_WAIT = 3'h2,
    ST_POWER_DOWN = 3'h3,
    ST_SELF_REF = 3'h4,
    ST_SR_EXIT = 3'h5
  } srps_state_t;

endpackage
`default_nettype wire

// ---- srps_monitor.sv ----
`timescale 1ns/1ns
`default_nettype none
module srps_monitor
  import srps_pkg::*;
#(
  parameter int REF_PERIOD_CYC = 2000,
  parameter int REF_INTERVAL_CYC = 20
) (
  // clock and requests
  input wire logic clk,
  input wire logic nrst,
  input wire logic pd_req,
  input wire logic sr_req,
  // status and pins
  input wire logic in_power_down,
  input wire logic in_self_refresh,
  input wire srps_pkg::srps_pins_t pins
);
  // ------------
  // pin decode
  // ------------
  logic [3:0] code;
  logic quiet;
  logic [15:0] age;
  assign code = pins.cmd[17:14];
  assign quiet = pins.cmd.cs_n || code[2:0] == 3'h7;
  // cycles since the last refresh; self refresh keeps rows alive itself
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) age <= 16'h0;
    else age <= (code == CMD_REFRESH || in_self_refresh) ? 16'h0 : age + 16'h1;
  end
  // ------------
  // properties
  // ------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  a_rfc_quiet: assert property (code == CMD_REFRESH && pins.cke |=> quiet [*3])
    else $error("command inside refresh cycle");
  a_sr_hold: assert property (code == CMD_REFRESH && !pins.cke |=> (!pins.cke && quiet) [*2])
    else $error("self refresh left early");
  a_sr_stay: assert property (in_self_refresh && !pins.cke && sr_req |=> !pins.cke)
    else $error("cke rose during self refresh");
  a_sr_exit: assert property ($rose(pins.cke) && in_self_refresh |-> (pins.cke && quiet) [*2])
    else $error("short self refresh exit");
  a_pd_pins: assert property (in_power_down |-> !pins.cke && quiet)
    else $error("power-down pins wrong");
  a_pd_exit: assert property (in_power_down && !pd_req |=> pins.cke && quiet && !in_power_down)
    else $error("power-down exit wrong");
  a_ref_due: assert property (age < 16'(REF_INTERVAL_CYC + 8))
    else $error("refresh overdue");
  a_cke_quiet: assert property (!pins.cke && code != CMD_REFRESH |-> quiet)
    else $error("command while cke low");
endmodule // srps_monitor

bind srps_ctrl srps_monitor #(.REF_PERIOD_CYC(REF_PERIOD_CYC), .REF_INTERVAL_CYC(REF_INTERVAL_CYC))
  u_mon (.clk(clk), .nrst(nrst), .pd_req(pd_req), .sr_req(sr_req),
  .in_power_down(in_power_down), .in_self_refresh(in_self_refresh), .pins(pins));
`default_nettype wire

// ---- srps_dev.sv ----
`timescale 1ns/1ns
`default_nettype none
module srps_dev
  import srps_pkg::*;
(
  // pins from the controller
  input wire logic clk,
  input wire srps_pkg::srps_pins_t pins,
  // state shown to the bench
  output logic [ADDR_W-1:0] row,
  output logic self_ref,
  output logic [3:0] beats,
  output logic [15:0] faults
);
  logic [3:0] code;
  logic quiet;
  logic cke_q = 1'b0;
  logic pd = 1'b0;
  logic [3:0] open_banks = 4'h0;
  int rfc = 0;
  int xsr = 0;
  int dwell = 0;
  assign code = pins.cmd[17:14];
  assign quiet = pins.cmd.cs_n || code[2:0] == 3'h7;
  initial row = '0;
  initial self_ref = 1'b0;
  initial beats = 4'h0;
  initial faults = 16'h0;
  // outside self refresh and power-down, an edge only acts when cke was high on the edge before
  always @(posedge clk) begin
    cke_q <= pins.cke;
    dwell <= dwell + 1;
    if (self_ref) begin // only cke is heard here
      if (dwell % 8 == 7) row <= row + 1'b1; // own timebase
      if (pins.cke) begin
        self_ref <= 1'b0;
        xsr <= SELF_REFRESH_EXIT_MIN_CLKS;
        if (dwell < ROW_ACTIVE_CYC) faults <= faults + 1'b1;
      end
    end else if (pd) begin
      if (pins.cke) pd <= 1'b0; // buffers off until cke
    end else if (cke_q) begin
      rfc <= (rfc > 0) ? rfc - 1 : 0;
      xsr <= (xsr > 0) ? xsr - 1 : 0;
      if (rfc + xsr > 0 && !quiet) faults <= faults + 1'b1;
      if (beats != 4'h0) beats <= beats - 1'b1;
      if (!pins.cke && quiet && beats == 4'h0) begin // busy burst means suspend
        pd <= 1'b1;
      end
      if (!quiet) case (code)
        CMD_REFRESH: begin // address ignored
          if (open_banks != 4'h0) faults <= faults + 1'b1;
          row <= row + 1'b1;
          rfc <= REFRESH_CYCLE_CYC - 1;
          self_ref <= !pins.cke;
          dwell <= 0;
        end
        CMD_ACTIVE: open_banks[pins.cmd.ba] <= 1'b1;
        CMD_PRECHARGE: open_banks <= pins.cmd.addr[PRE_ALL_BIT] ? 4'h0 :
          open_banks & ~(4'h1 << pins.cmd.ba);
        4'h4, 4'h5: beats <= 4'h4;
        default: ;
      endcase
    end
  end
endmodule // srps_dev
`default_nettype wire

// ---- tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import srps_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  srps_cmd_t usr_cmd = '0;
  logic usr_valid = 1'b0;
  logic burst_mode = 1'b0;
  logic pd_req = 1'b0;
  logic sr_req = 1'b0;
  logic suspend_req = 1'b0;
  logic usr_ready, in_pd, in_sr, busy, dev_sr;
  srps_pins_t pins;
  logic [ADDR_W-1:0] row;
  logic [3:0] beats, code_q, pre_ref;
  logic [15:0] faults;
  int mismatches = 0;
  int checks_done = 0;
  int cyc = 0;
  int last = 0;
  int gap = 0;
  int nref = 0;
  int want = 0;
  always #10 clk = ~clk;
  srps_ctrl #(.REF_PERIOD_CYC(2000), .REF_INTERVAL_CYC(20)) u_dut (.clk(clk), .nrst(nrst),
    .ce(1'b1), .usr_cmd(usr_cmd), .usr_valid(usr_valid), .usr_ready(usr_ready),
    .burst_mode(burst_mode), .pd_req(pd_req), .sr_req(sr_req), .suspend_req(suspend_req),
    .in_power_down(in_pd), .in_self_refresh(in_sr), .refresh_busy(busy), .pins(pins));
  srps_dev u_dev (.clk(clk), .pins(pins), .row(row), .self_ref(dev_sr), .beats(beats),
    .faults(faults));
  // log refreshes with their spacing and the command before each
  always @(posedge clk) begin
    cyc <= cyc + 1;
    code_q <= pins.cmd[17:14];
    if (pins.cmd[17:14] == CMD_REFRESH && pins.cke) begin
      nref <= nref + 1;
      gap <= cyc - last;
      last <= cyc;
      pre_ref <= code_q;
    end
  end
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic conclude();
    if (mismatches == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  function automatic logic cond(input int k);
    case (k)
      0: return usr_ready;
      1: return in_pd;
      2: return !in_pd;
      3: return in_sr;
      4: return !in_sr;
      5: return beats == 4'h0;
      default: return nref >= want;
    endcase
  endfunction
  // bounded wait, sampled on the falling edge once outputs settle
  task automatic await(input int k);
    int n;
    @(negedge clk);
    for (n = 0; n < 3000 && cond(k) !== 1'b1; n++) @(negedge clk);
    chk("wait", 32'(n < 3000), 32'h1);
    if (n == 3000) conclude();
  endtask
  task automatic send(input srps_cmd_t c);
    int n;
    await(0);
    @(posedge clk);
    usr_cmd <= c;
    usr_valid <= 1'b1;
    n = 0;
    do @(posedge clk); while (usr_ready !== 1'b1 && ++n < 50);
    usr_valid <= 1'b0;
  endtask
  task automatic t_refresh();
    want = nref + 3;
    await(6);
    chk("gap", 32'(gap), 32'd20);
    chk("faults", 32'(faults), 32'h0);
  endtask
  task automatic t_precharge();
    send({CMD_ACTIVE, 2'h2, 12'h0});
    want = nref + 1;
    await(6);
    chk("before refresh", 32'(pre_ref), 32'(CMD_PRECHARGE));
    chk("faults", 32'(faults), 32'h0);
  endtask
  task automatic t_power_down();
    @(posedge clk);
    pd_req <= 1'b1;
    await(1);
    chk("pd cke", 32'(pins.cke), 32'h0);
    await(2); // an owed refresh ends power-down
    await(1);
    @(posedge clk);
    pd_req <= 1'b0;
    await(2);
    chk("pd exit cke", 32'(pins.cke), 32'h1);
  endtask
  task automatic t_self_refresh();
    logic [ADDR_W-1:0] r0;
    int n0;
    @(posedge clk);
    sr_req <= 1'b1;
    await(3);
    r0 = row;
    n0 = nref;
    repeat (60) @(negedge clk);
    chk("sr refreshes", 32'(nref - n0), 32'h0);
    chk("sr row moved", 32'(row != r0), 32'h1);
    chk("sr device", 32'(dev_sr), 32'h1);
    @(posedge clk);
    sr_req <= 1'b0;
    await(4);
    chk("faults", 32'(faults), 32'h0);
  endtask
  task automatic t_suspend();
    logic [3:0] b0;
    send({4'h5, 2'h0, 12'h0});
    suspend_req <= 1'b1;
    repeat (3) @(negedge clk);
    b0 = beats;
    repeat (3) @(negedge clk);
    chk("frozen beats", 32'(beats), 32'(b0));
    chk("burst held", 32'(b0 != 4'h0), 32'h1);
    @(posedge clk);
    suspend_req <= 1'b0;
    await(5);
  endtask
  task automatic t_burst();
    @(posedge clk);
    burst_mode <= 1'b1;
    want = nref + 5;
    await(6);
    chk("burst gap", 32'(gap), 32'(REFRESH_CYCLE_CYC + 1));
    chk("row", 32'(row != 12'h0), 32'h1);
  endtask
  // reset, then each scenario in turn
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    t_refresh();
    t_precharge();
    t_power_down();
    t_self_refresh();
    t_refresh();
    t_suspend();
    t_burst();
    conclude();
  end
endmodule // tb_top
`default_nettype wire
